// *** rtl/tpn_access_ctrl.sv ***
// Token passing media access controller for one node of a multidrop network.
// How it works
// - Only initiators rotate the token; responders just answer, never hold it.
// - Packets are started only while this node holds the token.
// - One message per token visit, resent at most twice on failure.
// - After its message the holder sends a token pass to its successor.
// - Silence after a pass resends it; after three tries a search begins.
// - Search wraps to zero after the configurable maximum address, default 31.
// - Initiator addresses 0 to 31 are accepted.
// - Responder addresses 1 to 31 are accepted; zero is refused.
// - Idle medium beyond the link dead time makes the initiator claim.
// - Claim delay grows with address so the lowest address claims first.
// - Unknown or failed successor starts a linear search above own address.
// - A found initiator gets the token; its return marks normal operation.
// - Up to 32 nodes; join or leave disturbs nobody else.
// - A probe costs a pass time plus one slot timeout before moving on.
`timescale 1ns/100ps
`default_nettype none
module tpn_access_ctrl
   import tpn_pkg::*;
#(
   parameter logic [4:0] MAX_ADDR = TPN_MAX_ADDR_DFLT,
   parameter int LINK_DEAD_CYC = TPN_LINK_DEAD_CYC,
   parameter int SLOT_CYC = TPN_SLOT_CYC,
   parameter int PASS_WAIT_CYC = TPN_PASS_WAIT_CYC
) (
   // Clock and reset
   input wire logic mclk_in,
   input wire logic sys_rst_in,
   // Node configuration
   input wire logic is_initiator_in,
   input wire logic [TPN_ADDR_W-1:0] own_addr_in,
   // Medium status and decoded receive events
   input wire logic link_active_in,
   input wire logic rx_token_in,
   input wire logic rx_reply_in,
   // Message source
   input wire logic msg_pending_in,
   input wire logic [TPN_ADDR_W-1:0] msg_dest_in,
   output logic msg_ack_out,
   // Transmitter
   output logic tx_start_out,
   output tpn_pkg::tpn_kind_e tx_kind_out,
   output logic [TPN_ADDR_W-1:0] tx_dest_out,
   input wire logic tx_done_in,
   input wire logic tx_ok_in,
   // Status
   output logic addr_valid_out,
   output logic token_held_out,
   output logic ring_up_out,
   output logic succ_known_out,
   output logic [TPN_ADDR_W-1:0] succ_addr_out
);
   import tpn_pkg::*;

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_LISTEN,
      ST_HOLD,
      ST_TX,
      ST_PASS_WAIT,
      ST_SOL_WAIT
   } tpn_state_e;

   typedef struct packed {
      logic act_meta;
      logic act_sync;
      tpn_state_e st;
      logic [TPN_ADDR_W-1:0] succ;
      logic succ_ok;
      logic [TPN_ADDR_W-1:0] probe;
      logic [1:0] tries;
      logic claimed;
      logic ring_up;
      logic tx_start;
      tpn_kind_e kind;
      logic [TPN_ADDR_W-1:0] dest;
      logic tmr_clr;
      logic msg_ack;
   } tpn_main_s;

   tpn_main_s s;
   tpn_main_s next_s;
   logic node_ok;
   logic [TPN_TMR_W-1:0] claim_limit;

   tpn_tmr_if tif ();

   tpn_idle_timer u_idle_timer (
      .mclk_in(mclk_in),
      .sys_rst_in(sys_rst_in),
      .tif(tif)
   );

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   // Search wrap at maximum.
   function automatic logic [TPN_ADDR_W-1:0] f_next_addr(input logic [TPN_ADDR_W-1:0] a);
      f_next_addr = (a >= MAX_ADDR) ? TPN_ADDR_ZERO : a + 5'h01;
   endfunction : f_next_addr

   function automatic tpn_main_s f_send(input tpn_main_s x, input tpn_kind_e k,
                                        input logic [TPN_ADDR_W-1:0] d);
      tpn_main_s y;
      y = x;
      y.tx_start = 1'b1;
      y.kind = k;
      y.dest = d;
      y.st = ST_TX;
      f_send = y;
   endfunction : f_send

   // Hand the token on: pass to a known successor, else probe above own address.
   function automatic tpn_main_s f_hand_on(input tpn_main_s x,
                                           input logic [TPN_ADDR_W-1:0] own);
      tpn_main_s y;
      y = x;
      y.tries = 2'h0;
      if (x.succ_ok) begin
         y = f_send(y, TPN_KIND_PASS, x.succ);
      end else begin
         y.probe = f_next_addr(own);
         y = f_send(y, TPN_KIND_SOLICIT, y.probe);
      end
      f_hand_on = y;
   endfunction : f_hand_on

   // ----------------------------------------------------------------
   // Address checks
   // ----------------------------------------------------------------
   // Five bit addresses give 32 nodes.
   assign addr_valid_out = (own_addr_in <= TPN_ADDR_MAX) &&
                           (is_initiator_in || (own_addr_in != TPN_ADDR_ZERO));
   assign node_ok = is_initiator_in && addr_valid_out;

   // ----------------------------------------------------------------
   // Timer limits
   // ----------------------------------------------------------------
   // Higher addresses wait one slot longer per address step.
   assign claim_limit = TPN_TMR_W'(LINK_DEAD_CYC) +
                        TPN_TMR_W'(TPN_TMR_W'(own_addr_in) * TPN_TMR_W'(SLOT_CYC));

   always_comb begin
      case (s.st)
         ST_PASS_WAIT: tif.limit = TPN_TMR_W'(PASS_WAIT_CYC);
         // Probe wait adds a slot timeout.
         ST_SOL_WAIT: tif.limit = TPN_TMR_W'(PASS_WAIT_CYC) + TPN_TMR_W'(SLOT_CYC);
         default: tif.limit = claim_limit;
      endcase
   end

   // Any medium activity restarts the idle count.
   assign tif.restart = s.act_sync || s.tmr_clr;

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      next_s = s;
      next_s.act_meta = link_active_in;
      next_s.act_sync = s.act_meta;
      next_s.tx_start = 1'b0;
      next_s.tmr_clr = 1'b0;
      next_s.msg_ack = 1'b0;
      case (s.st)
         ST_LISTEN: begin
            if (rx_token_in) begin
               // Token back at the claimer closes the ring.
               if (s.claimed) begin
                  next_s.ring_up = 1'b1;
               end
               next_s.st = ST_HOLD;
            end else if (tif.expired) begin
               // Claim the token after link dead.
               next_s.claimed = 1'b1;
               next_s.ring_up = 1'b0;
               next_s.succ_ok = 1'b0;
               next_s.st = ST_HOLD;
            end
         end
         ST_HOLD: begin
            next_s.tries = 2'h0;
            if (msg_pending_in) begin
               next_s = f_send(next_s, TPN_KIND_MSG, msg_dest_in);
            end else begin
               next_s = f_hand_on(next_s, own_addr_in);
            end
         end
         ST_TX: begin
            if (tx_done_in) begin
               case (s.kind)
                  TPN_KIND_MSG: begin
                     // Retry a failed message twice at most.
                     if (!tx_ok_in && (s.tries < TPN_MSG_RETRIES)) begin
                        next_s.tries = s.tries + 2'h1;
                        next_s = f_send(next_s, TPN_KIND_MSG, s.dest);
                     end else begin
                        next_s.msg_ack = 1'b1;
                        next_s = f_hand_on(next_s, own_addr_in);
                     end
                  end
                  TPN_KIND_PASS: begin
                     next_s.tmr_clr = 1'b1;
                     next_s.st = ST_PASS_WAIT;
                  end
                  default: begin
                     next_s.tmr_clr = 1'b1;
                     next_s.st = ST_SOL_WAIT;
                  end
               endcase
            end
         end
         ST_PASS_WAIT: begin
            if (s.act_sync) begin
               next_s.tmr_clr = 1'b1;
               next_s.st = ST_LISTEN;
            end else if (tif.expired) begin
               // Three silent passes start a new search.
               if (s.tries == TPN_PASS_TRIES - 2'h1) begin
                  next_s.succ_ok = 1'b0;
                  next_s = f_hand_on(next_s, own_addr_in);
               end else begin
                  next_s.tries = s.tries + 2'h1;
                  next_s = f_send(next_s, TPN_KIND_PASS, s.succ);
               end
            end
         end
         ST_SOL_WAIT: begin
            if (rx_reply_in) begin
               next_s.succ = s.probe;
               next_s.succ_ok = 1'b1;
               next_s.tries = 2'h0;
               next_s = f_send(next_s, TPN_KIND_PASS, s.probe);
            end else if (tif.expired) begin
               // Step on, wrapping at the maximum.
               next_s.probe = f_next_addr(s.probe);
               if (next_s.probe == own_addr_in) begin
                  // Nobody else answered, so this node keeps the token alone.
                  next_s.st = ST_HOLD;
               end else begin
                  next_s = f_send(next_s, TPN_KIND_SOLICIT, next_s.probe);
               end
            end
         end
         default: begin
            next_s.st = ST_LISTEN;
         end
      endcase
      // A responder or badly addressed node never joins the rotation.
      if (!node_ok) begin
         next_s.st = ST_LISTEN;
         next_s.tx_start = 1'b0;
         next_s.claimed = 1'b0;
         next_s.ring_up = 1'b0;
      end
   end

   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign tx_start_out = s.tx_start;
   assign tx_kind_out = s.kind;
   assign tx_dest_out = s.dest;
   assign msg_ack_out = s.msg_ack;
   assign token_held_out = (s.st != ST_LISTEN) && (s.st != ST_PASS_WAIT);
   assign ring_up_out = s.ring_up;
   assign succ_known_out = s.succ_ok;
   assign succ_addr_out = s.succ;
endmodule : tpn_access_ctrl
`default_nettype wire

// *** rtl/tpn_idle_timer.sv ***
// Idle timer: counts cycles since the last restart and flags when a limit is reached.
`timescale 1ns/100ps
`default_nettype none
module tpn_idle_timer
   import tpn_pkg::*;
(
   // Clock and reset
   input wire logic mclk_in,
   input wire logic sys_rst_in,
   // Controller side
   tpn_tmr_if.tmr tif
);
   import tpn_pkg::*;

   typedef struct packed {
      logic [TPN_TMR_W-1:0] cnt;
   } tpn_tmr_s;

   tpn_tmr_s s;
   tpn_tmr_s next_s;

   always_comb begin
      next_s = s;
      if (tif.restart) begin
         next_s.cnt = '0;
      end else if (s.cnt < tif.limit) begin
         next_s.cnt = s.cnt + 1'b1;
      end
   end

   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   // Limit may shrink while counting, so compare with at-or-above.
   assign tif.expired = (s.cnt >= tif.limit) && !tif.restart;
endmodule : tpn_idle_timer
`default_nettype wire

// *** rtl/tpn_pkg.sv ***
// Shared constants and types for the token passing network access block.
package tpn_pkg;
   // ----------------------------------------------------------------
   // Addressing
   // ----------------------------------------------------------------
   localparam int TPN_ADDR_W = 5;
   localparam logic [4:0] TPN_ADDR_ZERO = 5'h00;
   localparam logic [4:0] TPN_ADDR_MAX = 5'h1f;
   localparam logic [4:0] TPN_MAX_ADDR_DFLT = 5'h1f;

   // ----------------------------------------------------------------
   // Counts
   // ----------------------------------------------------------------
   localparam logic [1:0] TPN_MSG_RETRIES = 2'h2;
   localparam logic [1:0] TPN_PASS_TRIES = 2'h3;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int TPN_TMR_W = 24;
   localparam int TPN_CLK_PERIOD_NS = 8;
   localparam int TPN_LINK_DEAD_NS = 1000000;
   localparam int TPN_SLOT_NS = 40000;
   localparam int TPN_PASS_WAIT_NS = 16000;
   // Waits are least times, so they round up to whole cycles.
   localparam int TPN_LINK_DEAD_CYC =
      (TPN_LINK_DEAD_NS + TPN_CLK_PERIOD_NS - 1) / TPN_CLK_PERIOD_NS;
   localparam int TPN_SLOT_CYC = (TPN_SLOT_NS + TPN_CLK_PERIOD_NS - 1) / TPN_CLK_PERIOD_NS;
   localparam int TPN_PASS_WAIT_CYC =
      (TPN_PASS_WAIT_NS + TPN_CLK_PERIOD_NS - 1) / TPN_CLK_PERIOD_NS;

   // ----------------------------------------------------------------
   // Packet kinds requested from the transmitter
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      TPN_KIND_MSG,
      TPN_KIND_PASS,
      TPN_KIND_SOLICIT
   } tpn_kind_e;
endpackage : tpn_pkg

// *** rtl/tpn_tmr_if.sv ***
// Carrier between the access controller and its idle timer.
`timescale 1ns/100ps
`default_nettype none
interface tpn_tmr_if;
   import tpn_pkg::*;
   logic restart;
   logic [TPN_TMR_W-1:0] limit;
   logic expired;

   modport ctrl (output restart, output limit, input expired);
   modport tmr (input restart, input limit, output expired);
endinterface : tpn_tmr_if
`default_nettype wire

// *** testbench/token_passing_network_access_test.sv ***
// Self-checking bench for the access controller.
`timescale 1ns/100ps
`default_nettype none
module token_passing_network_access_test;
   import tpn_pkg::*;
   localparam logic [4:0] MAXA = 5'h03;
   logic mclk_in = 1'b0;
   logic sys_rst_in = 1'b1;
   logic is_init = 1'b1, rx_token = 1'b0, msg_pend = 1'b0, msg_ok = 1'b1, peer_en = 1'b0;
   logic [4:0] own = 5'h01, msg_dest = 5'h07, peer = 5'h02, succ;
   logic link, rx_reply, ack, start, done, ok, aval, held, ring, sknown;
   tpn_kind_e kind;
   logic [4:0] dest;
   int err_total = 0, check_count = 0, cycles = 0, cyc;
   always #4 mclk_in = ~mclk_in;
   tpn_access_ctrl #(.MAX_ADDR(MAXA), .LINK_DEAD_CYC(200), .SLOT_CYC(20), .PASS_WAIT_CYC(10))
   uut (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .is_initiator_in(is_init),
      .own_addr_in(own), .link_active_in(link), .rx_token_in(rx_token), .rx_reply_in(rx_reply),
      .msg_pending_in(msg_pend), .msg_dest_in(msg_dest), .msg_ack_out(ack),
      .tx_start_out(start), .tx_kind_out(kind), .tx_dest_out(dest), .tx_done_in(done),
      .tx_ok_in(ok), .addr_valid_out(aval), .token_held_out(held), .ring_up_out(ring),
      .succ_known_out(sknown), .succ_addr_out(succ));
   tpn_net_model u_net (.mclk_in(mclk_in), .tx_start_in(start), .tx_kind_in(kind),
      .tx_dest_in(dest), .msg_ok_in(msg_ok), .peer_en_in(peer_en), .peer_addr_in(peer),
      .tx_done_out(done), .tx_ok_out(ok), .rx_reply_out(rx_reply), .link_active_out(link));
   task check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_total++;
         $display("ERROR at %0t: saw %0h, expected %0h", $time, seen, exp);
      end
   endtask : check
   task wait_start(input int limit);
      cyc = 0;
      @(negedge mclk_in);
      while (start !== 1'b1 && cyc < limit) begin
         @(negedge mclk_in);
         cyc++;
      end
   endtask : wait_start
   task do_reset(input logic init, input logic [4:0] addr);
      @(negedge mclk_in);
      sys_rst_in = 1'b1;
      is_init = init;
      own = addr;
      repeat (3) @(negedge mclk_in);
      sys_rst_in = 1'b0;
   endtask : do_reset
   task give_token;
      rx_token = 1'b1;
      @(negedge mclk_in);
      rx_token = 1'b0;
   endtask : give_token
   task t_claim;
      do_reset(1'b1, 5'h01);
      peer_en = 1'b1;
      wait_start(400);
      check(cyc >= 220 && cyc <= 232, 1);
      check(kind, TPN_KIND_SOLICIT);
      check(dest, 5'h02);
      wait_start(50);
      check(kind, TPN_KIND_PASS);
      check({sknown, succ}, {1'b1, 5'h02});
      repeat (20) @(negedge mclk_in);
      check(held, 0);
      give_token;
      @(negedge mclk_in);
      check(ring, 1);
      check(held, 1);
      $display("t_claim finished");
   endtask : t_claim
   task t_msg_retry;
      msg_ok = 1'b0;
      msg_pend = 1'b1;
      repeat (20) @(negedge mclk_in);
      give_token;
      for (int i = 0; i < 3; i++) begin
         wait_start(60);
         check({kind, dest}, {TPN_KIND_MSG, 5'h07});
      end
      wait_start(60);
      check({kind, ack}, {TPN_KIND_PASS, 1'b1});
      msg_pend = 1'b0;
      repeat (20) @(negedge mclk_in);
      msg_ok = 1'b1;
      msg_pend = 1'b1;
      give_token;
      wait_start(60);
      check({kind, dest}, {TPN_KIND_MSG, 5'h07});
      wait_start(60);
      check({kind, ack}, {TPN_KIND_PASS, 1'b1});
      msg_pend = 1'b0;
      $display("t_msg_retry finished");
   endtask : t_msg_retry
   task t_pass_fail;
      repeat (20) @(negedge mclk_in);
      peer_en = 1'b0;
      give_token;
      for (int i = 0; i < 3; i++) begin
         wait_start(80);
         check(kind, TPN_KIND_PASS);
      end
      for (int i = 0; i < 3; i++) begin
         wait_start(100);
         check({kind, dest}, {TPN_KIND_SOLICIT, 5'((own + 1 + i) % (MAXA + 1))});
         if (i > 0) check(cyc >= 30 && cyc <= 40, 1);
      end
      wait_start(100);
      check({kind, dest, held}, {TPN_KIND_SOLICIT, 5'h02, 1'b1});
      $display("t_pass_fail finished");
   endtask : t_pass_fail
   task t_addr;
      do_reset(1'b0, 5'h01);
      wait_start(400);
      check({start, held}, 2'b00);
      for (int a = 0; a < 64; a++) begin
         if (a == 32) do_reset(1'b1, 5'h00);
         own = 5'(a);
         @(negedge mclk_in);
         check(aval, a >= 32 || a != 0);
      end
      do_reset(1'b1, 5'h00);
      wait_start(400);
      check(cyc >= 200 && cyc <= 212, 1);
      check({kind, dest}, {TPN_KIND_SOLICIT, 5'h01});
      $display("t_addr finished");
   endtask : t_addr
   task wrap_up;
      $display("Comparisons %0d, mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : wrap_up
   always @(posedge mclk_in) begin
      cycles++;
      if (cycles == 5000) begin
         err_total++;
         wrap_up;
      end
   end
   initial begin
      t_claim;
      t_msg_retry;
      t_pass_fail;
      t_addr;
      wrap_up;
   end
endmodule : token_passing_network_access_test
`default_nettype wire

// *** testbench/tpn_access_properties.sv ***
// Port-level checks for the access controller.
`timescale 1ns/100ps
`default_nettype none
module tpn_access_props
   import tpn_pkg::*;
#(
   parameter logic [4:0] MAX_ADDR = TPN_MAX_ADDR_DFLT
) (
   // Clock and reset
   input wire logic mclk_in,
   input wire logic sys_rst_in,
   // Watched ports
   input wire logic is_initiator_in,
   input wire logic [TPN_ADDR_W-1:0] own_addr_in,
   input wire logic link_active_in,
   input wire logic rx_token_in,
   input wire logic rx_reply_in,
   input wire logic msg_ack_out,
   input wire logic tx_start_out,
   input wire tpn_pkg::tpn_kind_e tx_kind_out,
   input wire logic [TPN_ADDR_W-1:0] tx_dest_out,
   input wire logic addr_valid_out,
   input wire logic token_held_out,
   input wire logic succ_known_out,
   input wire logic [TPN_ADDR_W-1:0] succ_addr_out
);
   default clocking @(posedge mclk_in); endclocking
   default disable iff (sys_rst_in);
   logic [2:0] msg_cnt;
   logic [2:0] pass_cnt;
   tpn_kind_e prev_kind;
   logic [4:0] prev_dest;
   function automatic logic [4:0] nxt(input logic [4:0] a);
      return (a == MAX_ADDR) ? 5'h00 : a + 5'h01;
   endfunction : nxt
   // The message count restarts on another kind of packet; the pass count also restarts on medium activity or a received token.
   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         msg_cnt <= 3'h0;
         pass_cnt <= 3'h0;
         prev_kind <= TPN_KIND_MSG;
         prev_dest <= 5'h00;
      end else begin
         if (tx_start_out) begin
            prev_kind <= tx_kind_out;
            prev_dest <= tx_dest_out;
         end
         if (tx_start_out) begin
            msg_cnt <= (tx_kind_out == TPN_KIND_MSG) ? msg_cnt + 3'h1 : 3'h0;
         end
         if (link_active_in || rx_token_in) begin
            pass_cnt <= 3'h0;
         end else if (tx_start_out) begin
            pass_cnt <= (tx_kind_out == TPN_KIND_PASS) ? pass_cnt + 3'h1 : 3'h0;
         end
      end
   end
   sequence s_pass_start;
      tx_start_out && tx_kind_out == TPN_KIND_PASS;
   endsequence
   a_responder_stays_silent: assert property ((!is_initiator_in && !$past(is_initiator_in))
      |-> !tx_start_out) else $error("Responder started a packet.");
   a_start_needs_token: assert property (tx_start_out |-> token_held_out)
      else $error("Packet started without the token.");
   a_msg_three_max: assert property (msg_cnt <= 3'h3)
      else $error("More than three message sends.");
   a_ack_hands_on: assert property (msg_ack_out |-> tx_start_out
      && tx_kind_out != TPN_KIND_MSG) else $error("Message end without hand-on.");
   a_pass_three_max: assert property (pass_cnt <= 3'h3)
      else $error("More than three silent passes.");
   a_first_probe: assert property ((tx_start_out && tx_kind_out == TPN_KIND_SOLICIT
      && prev_kind == TPN_KIND_PASS) |-> tx_dest_out == nxt(own_addr_in))
      else $error("Search did not start above own address.");
   a_search_wraps: assert property ((tx_start_out && tx_kind_out == TPN_KIND_SOLICIT
      && prev_kind == TPN_KIND_SOLICIT) |-> tx_dest_out == nxt(prev_dest)
      || (nxt(prev_dest) == own_addr_in && tx_dest_out == nxt(own_addr_in)))
      else $error("Probe address out of sequence.");
   a_pass_to_succ: assert property (s_pass_start |-> succ_known_out
      && tx_dest_out == succ_addr_out) else $error("Pass not sent to the successor.");
   a_reply_takes_pass: assert property ((rx_reply_in && token_held_out && !tx_start_out
      && prev_kind == TPN_KIND_SOLICIT) |=> s_pass_start ##0 succ_addr_out == $past(prev_dest))
      else $error("Reply did not hand the token on.");
   a_addr_valid_map: assert property (addr_valid_out == (is_initiator_in
      || own_addr_in != 5'h00)) else $error("Address check wrong.");
endmodule : tpn_access_props
bind tpn_access_ctrl tpn_access_props #(.MAX_ADDR(MAX_ADDR)) u_props (
   .mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .is_initiator_in(is_initiator_in),
   .own_addr_in(own_addr_in), .link_active_in(link_active_in), .rx_token_in(rx_token_in),
   .rx_reply_in(rx_reply_in), .msg_ack_out(msg_ack_out), .tx_start_out(tx_start_out),
   .tx_kind_out(tx_kind_out), .tx_dest_out(tx_dest_out), .addr_valid_out(addr_valid_out),
   .token_held_out(token_held_out), .succ_known_out(succ_known_out),
   .succ_addr_out(succ_addr_out));
`default_nettype wire

// *** testbench/tpn_net_model.sv ***
// Transmitter and far nodes: one live peer answers probes and takes passes.
`timescale 1ns/100ps
`default_nettype none
module tpn_net_model
   import tpn_pkg::*;
(
   // Clock
   input wire logic mclk_in,
   // Controller requests
   input wire logic tx_start_in,
   input wire tpn_pkg::tpn_kind_e tx_kind_in,
   input wire logic [TPN_ADDR_W-1:0] tx_dest_in,
   // Scenario controls
   input wire logic msg_ok_in,
   input wire logic peer_en_in,
   input wire logic [TPN_ADDR_W-1:0] peer_addr_in,
   // Answers
   output logic tx_done_out,
   output logic tx_ok_out,
   output logic rx_reply_out,
   output logic link_active_out
);
   int busy = 0;
   int reply_dly = 0;
   int act_cnt = 0;
   tpn_kind_e kind = TPN_KIND_MSG;
   logic [4:0] dest = 5'h00;
   logic hit;
   initial begin
      tx_done_out = 1'b0;
      tx_ok_out = 1'b0;
      rx_reply_out = 1'b0;
      link_active_out = 1'b0;
   end
   // Outside a done pulse the status line shows the inverse, so it is never trusted.
   always @(negedge mclk_in) begin
      tx_done_out = 1'b0;
      rx_reply_out = 1'b0;
      tx_ok_out = ~msg_ok_in;
      hit = peer_en_in && dest == peer_addr_in;
      if (tx_start_in === 1'b1) begin
         busy = 3;
         kind = tx_kind_in;
         dest = tx_dest_in;
      end else if (busy > 0) begin
         busy = busy - 1;
         tx_done_out = (busy == 0);
         tx_ok_out = (busy == 0) ? msg_ok_in : ~msg_ok_in;
         // Only the live initiator peer answers a probe.
         if (busy == 0 && hit && kind == TPN_KIND_SOLICIT) reply_dly = 2;
         // A peer that takes the token starts talking.
         if (busy == 0 && hit && kind == TPN_KIND_PASS) act_cnt = 6;
      end
      if (reply_dly > 0) begin
         reply_dly = reply_dly - 1;
         rx_reply_out = (reply_dly == 0);
      end
      link_active_out = (act_cnt > 0);
      if (act_cnt > 0) act_cnt = act_cnt - 1;
   end
endmodule : tpn_net_model
`default_nettype wire
